// ===== src/t2c_timer2.sv
/*
  Timer2 control block: 16-bit timer/counter with run control,
  overflow and external-edge flags, capture/auto-reload and serial
  baud clock selection, plus interrupt status, clear and enable.
  Assumes pins arrive asynchronously and the other timer's overflow
  arrives as a one-cycle pulse on clk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "t2c_consts.svh"

// ----------------------------------------------------------------------
// pin synchroniser with falling edge detect
// ----------------------------------------------------------------------
module t2c_sync_fall (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // asynchronous pin
  input  wire logic pinAsync,
  // synchronised result
  output logic      pinFall
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  // the first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end else begin
      meta_q <= pinAsync;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // high sample followed by low sample
  assign pinFall = last_q & ~sync_q;

endmodule // t2c_sync_fall

// ----------------------------------------------------------------------
// timer2 top
// ----------------------------------------------------------------------
module t2c_timer2 (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                srst,
  // register port
  input  wire t2c_pkg::t2c_bus_req_t busReq,
  output logic [7:0]               regRdata,
  // pins
  input  wire logic                countInputPin,
  input  wire logic                externalTriggerPin,
  // serial port
  input  wire logic [1:0]          uartMode,
  input  wire logic                otherTimerOverflow,
  output t2c_pkg::t2c_baud_t       baudTick,
  // interrupt
  output logic                     irq
);
  import t2c_pkg::*;

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  t2c_ctrl_t   ctrl_q;
  logic [15:0] count_q;
  logic [15:0] pair_q;
  logic        prescale_q;
  logic [1:0]  irqStatus_q;
  logic [1:0]  irqEnable_q;
  logic [7:0]  rdata_q;
  logic        ovfTick_q;

  // --------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------
  logic wrCtrl;
  logic wrRldLo;
  logic wrRldHi;
  logic wrCntLo;
  logic wrCntHi;
  logic wrIrqClr;
  logic wrIrqEn;

  assign wrCtrl   = busReq.wr && busReq.addr == `T2C_ADDR_CTRL;
  assign wrRldLo  = busReq.wr && busReq.addr == `T2C_ADDR_RLD_LO;
  assign wrRldHi  = busReq.wr && busReq.addr == `T2C_ADDR_RLD_HI;
  assign wrCntLo  = busReq.wr && busReq.addr == `T2C_ADDR_CNT_LO;
  assign wrCntHi  = busReq.wr && busReq.addr == `T2C_ADDR_CNT_HI;
  assign wrIrqClr = busReq.wr && busReq.addr == `T2C_ADDR_IRQ_CLR;
  assign wrIrqEn  = busReq.wr && busReq.addr == `T2C_ADDR_IRQ_EN;

  // --------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------
  logic countPinFall;
  logic trigPinFall;

  t2c_sync_fall uCountSync (
    .clk      (clk),
    .srst     (srst),
    .pinAsync (countInputPin),
    .pinFall  (countPinFall)
  );

  t2c_sync_fall uTrigSync (
    .clk      (clk),
    .srst     (srst),
    .pinAsync (externalTriggerPin),
    .pinFall  (trigPinFall)
  );

  // --------------------------------------------------------------------
  // count tick
  // --------------------------------------------------------------------
  logic serialSel;
  logic divTick;
  logic countTick;
  logic overflow;
  logic extEvent;
  logic captureMode;

  assign serialSel = ctrl_q.serialRxClockSelect |
                     ctrl_q.serialTxClockSelect;

  // free-running divider so the timer rate does not depend on run
  always_ff @(posedge clk) begin
    if (srst) begin
      prescale_q <= 1'b0;
    end else if (prescale_q == 1'(`T2C_TIMER_DIV - 1)) begin
      prescale_q <= 1'b0;
    end else begin
      prescale_q <= prescale_q + 1'b1;
    end
  end

  assign divTick = prescale_q == 1'(`T2C_TIMER_DIV - 1);

  always_comb begin
    if (!ctrl_q.runControl) begin
      countTick = 1'b0;
    end else if (ctrl_q.countSourceSelect) begin
      countTick = countPinFall;
    end else begin
      countTick = divTick;
    end
  end

  assign overflow = countTick && count_q == 16'hffff;

  // serial selects block the pin entirely
  assign extEvent = trigPinFall & ctrl_q.externalPinEnable & ~serialSel;

  // serial selects force auto-reload
  assign captureMode = ctrl_q.captureReloadSelect & ~serialSel;

  // --------------------------------------------------------------------
  // counter
  // --------------------------------------------------------------------
  // software writes to the count take priority over counting
  always_ff @(posedge clk) begin
    if (srst) begin
      count_q <= `T2C_RST_WORD;
    end else if (wrCntLo) begin
      count_q[7:0] <= busReq.wdata;
    end else if (wrCntHi) begin
      count_q[15:8] <= busReq.wdata;
    end else if (extEvent && !captureMode) begin
      count_q <= pair_q;
    end else if (overflow && !captureMode) begin
      count_q <= pair_q;
    end else if (countTick) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // --------------------------------------------------------------------
  // reload / capture pair
  // --------------------------------------------------------------------
  // a capture wins over a software write in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      pair_q <= `T2C_RST_WORD;
    end else if (extEvent && captureMode) begin
      pair_q <= count_q;
    end else if (wrRldLo) begin
      pair_q[7:0] <= busReq.wdata;
    end else if (wrRldHi) begin
      pair_q[15:8] <= busReq.wdata;
    end
  end

  // --------------------------------------------------------------------
  // control register
  // --------------------------------------------------------------------
  t2c_ctrl_t ctrl_d;

  always_comb begin
    ctrl_d = ctrl_q;
    if (wrCtrl) begin
      ctrl_d = t2c_ctrl_t'(busReq.wdata);
    end
    // hardware set wins over a software clear in the same cycle
    if (overflow && !serialSel) begin
      ctrl_d.overflowFlag = 1'b1;
    end
    if (extEvent) begin
      ctrl_d.externalEdgeFlag = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q <= t2c_ctrl_t'(`T2C_RST_BYTE);
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // --------------------------------------------------------------------
  // serial baud ticks
  // --------------------------------------------------------------------
  logic baudMode;

  assign baudMode = uartMode[0]; // modes 1 and 3

  // every overflow is registered for the baud tick selects, even when the flag is not set
  always_ff @(posedge clk) begin
    if (srst) begin
      ovfTick_q <= 1'b0;
    end else begin
      ovfTick_q <= overflow;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      baudTick <= '0;
    end else begin
      baudTick.rxTick <= baudMode & (ctrl_q.serialRxClockSelect ?
                         ovfTick_q : otherTimerOverflow);
      baudTick.txTick <= baudMode & (ctrl_q.serialTxClockSelect ?
                         ovfTick_q : otherTimerOverflow);
    end
  end

  // --------------------------------------------------------------------
  // interrupt status, clear and enable
  // --------------------------------------------------------------------
  logic [1:0] irqEvent;

  assign irqEvent[`T2C_IRQ_OVF] = overflow & ~serialSel;
  assign irqEvent[`T2C_IRQ_EXT] = extEvent;

  // write one to clear; a new event in the same cycle stays set
  always_ff @(posedge clk) begin
    if (srst) begin
      irqStatus_q <= 2'h0;
    end else if (wrIrqClr) begin
      irqStatus_q <= (irqStatus_q & ~busReq.wdata[1:0]) | irqEvent;
    end else begin
      irqStatus_q <= irqStatus_q | irqEvent;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irqEnable_q <= 2'h0;
    end else if (wrIrqEn) begin
      irqEnable_q <= busReq.wdata[1:0];
    end
  end

  assign irq = |(irqStatus_q & irqEnable_q);

  // --------------------------------------------------------------------
  // read port
  // --------------------------------------------------------------------
  logic [7:0] rdata_d;

  always_comb begin
    case (busReq.addr)
      `T2C_ADDR_CTRL: begin
        rdata_d = ctrl_q;
      end
      `T2C_ADDR_RLD_LO: begin
        rdata_d = pair_q[7:0];
      end
      `T2C_ADDR_RLD_HI: begin
        rdata_d = pair_q[15:8];
      end
      `T2C_ADDR_CNT_LO: begin
        rdata_d = count_q[7:0];
      end
      `T2C_ADDR_CNT_HI: begin
        rdata_d = count_q[15:8];
      end
      `T2C_ADDR_IRQ_ST: begin
        rdata_d = {6'h00, irqStatus_q};
      end
      `T2C_ADDR_IRQ_EN: begin
        rdata_d = {6'h00, irqEnable_q};
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= 8'h00;
    end else if (busReq.rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign regRdata = rdata_q;

endmodule // t2c_timer2

`default_nettype wire

// ===== src/t2c_consts.svh
/*
  Constants of the timer2 control block: register offsets, field
  positions, reset values and counts.
  Assumes an 8-bit register port on the system clock.
*/
`ifndef T2C_CONSTS_SVH
`define T2C_CONSTS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define T2C_ADDR_CTRL    8'hc8
`define T2C_ADDR_RLD_LO  8'hca
`define T2C_ADDR_RLD_HI  8'hcb
`define T2C_ADDR_CNT_LO  8'hcc
`define T2C_ADDR_CNT_HI  8'hcd
`define T2C_ADDR_IRQ_ST  8'hd8
`define T2C_ADDR_IRQ_CLR 8'hd9
`define T2C_ADDR_IRQ_EN  8'hda

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define T2C_BIT_OVF      7
`define T2C_BIT_EXF      6
`define T2C_BIT_RXSEL    5
`define T2C_BIT_TXSEL    4
`define T2C_BIT_EXEN     3
`define T2C_BIT_RUN      2
`define T2C_BIT_CSRC     1
`define T2C_BIT_CAPT     0

// ----------------------------------------------------------------------
// interrupt status fields, reset values, counts
// ----------------------------------------------------------------------
`define T2C_IRQ_OVF      0
`define T2C_IRQ_EXT      1
`define T2C_RST_BYTE     8'h00
`define T2C_RST_WORD     16'h0000
`define T2C_TIMER_DIV    2

`endif

// ===== src/t2c_pkg.sv
/*
  Types of the timer2 control block.
  Assumes t2c_consts.svh supplies all numeric constants.
*/
`default_nettype none

package t2c_pkg;

  // register port request, one cycle per access
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } t2c_bus_req_t;

  // timer control and status byte, bit 7 first
  typedef struct packed {
    logic overflowFlag;
    logic externalEdgeFlag;
    logic serialRxClockSelect;
    logic serialTxClockSelect;
    logic externalPinEnable;
    logic runControl;
    logic countSourceSelect;
    logic captureReloadSelect;
  } t2c_ctrl_t;

  // serial port baud tick outputs, receive and transmit
  typedef struct packed {
    logic rxTick;
    logic txTick;
  } t2c_baud_t;

endpackage

`default_nettype wire

// ===== tb/t2c_timer2_props.sv
/*
  Port checker of the timer2 control block.
  Assumes it is bound to t2c_timer2 and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none
module t2c_timer2_props (
  // clock and reset
  input wire logic                  clk,
  input wire logic                  srst,
  // register port
  input wire t2c_pkg::t2c_bus_req_t busReq,
  input wire logic [7:0]            regRdata,
  // serial port and interrupt
  input wire logic [1:0]            uartMode,
  input wire t2c_pkg::t2c_baud_t    baudTick,
  input wire logic                  irq
);
  import t2c_pkg::*;
  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_lone_read;
    busReq.rd ##1 !busReq.rd;
  endsequence
  sequence s_no_mode_rx;
    !uartMode[0] [*3];
  endsequence
  a_rdata_idle: assert property (!$past(busReq.rd) |-> regRdata == 8'h00)
    else $error("read data outside its cycle");
  a_rdata_stand: assert property (s_lone_read |=> regRdata == 8'h00)
    else $error("read data stood too long");
  a_unmapped_read: assert property (busReq.rd && busReq.addr == 8'hc9 |=> regRdata == 8'h00)
    else $error("unmapped read gave data");
  a_rx_gate: assert property (s_no_mode_rx |=> !baudTick.rxTick)
    else $error("rx tick outside modes 1 and 3");
  a_tx_gate: assert property (!uartMode[0] [*3] |=> !baudTick.txTick)
    else $error("tx tick outside modes 1 and 3");
  a_tick_pulse: assert property (baudTick.rxTick |=> !baudTick.rxTick)
    else $error("rx tick longer than a cycle");
  a_irq_fall: assert property ($fell(irq) |-> $past(busReq.wr))
    else $error("irq dropped without a write");
  a_reset_quiet: assert property ($fell(srst) |-> !irq && regRdata == 8'h00 && baudTick == '0)
    else $error("outputs not clear after reset");
endmodule // t2c_timer2_props
bind t2c_timer2 t2c_timer2_props i_props (
  .clk(clk), .srst(srst), .busReq(busReq), .regRdata(regRdata),
  .uartMode(uartMode), .baudTick(baudTick), .irq(irq)
);
`default_nettype wire

// ===== tb/t2c_testbench.sv
/*
  Self-checking bench of the timer2 control block.
  Assumes the register map of t2c_consts.svh and a 125 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import t2c_pkg::*;
  logic         clk = 1'b0;
  logic         srst = 1'b1;
  t2c_bus_req_t busReq = '0;
  logic [7:0]   regRdata;
  logic         cntPin = 1'b1;
  logic         trigPin = 1'b1;
  logic [1:0]   uartMode = 2'h0;
  logic         otherOvf = 1'b0;
  t2c_baud_t    baudTick;
  logic         irq;
  logic [7:0]   v;
  int           miscompares = 0;
  int           checked = 0;
  int           cycles = 0;
  int           rxSeen = 0;
  int           txSeen = 0;
  always #4 clk = ~clk;
  t2c_timer2 i_dut (
    .clk(clk), .srst(srst), .busReq(busReq), .regRdata(regRdata),
    .countInputPin(cntPin), .externalTriggerPin(trigPin), .uartMode(uartMode),
    .otherTimerOverflow(otherOvf), .baudTick(baudTick), .irq(irq)
  );
  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic summarize();
    $display("compares %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge clk);
  endtask
  // a gap cycle follows every access so no strobe is assigned twice
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    pause(1);
    busReq <= '0;
    pause(1);
  endtask
  task automatic rdv(input logic [7:0] a, output logic [7:0] d);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    pause(1);
    busReq <= '0;
    #1 d = regRdata;
    pause(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rdv(a, d);
    check($sformatf("reg %h", a), d, e);
  endtask
  task automatic fall();
    trigPin <= 1'b0;
    pause(6);
    trigPin <= 1'b1;
    pause(4);
  endtask
  task automatic pulse();
    otherOvf <= 1'b1;
    pause(1);
    otherOvf <= 1'b0;
    pause(5);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (baudTick.rxTick === 1'b1) rxSeen++;
    if (baudTick.txTick === 1'b1) txSeen++;
    if (cycles == 3000) begin
      miscompares++;
      summarize();
    end
  end
  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    pause(12);
    srst <= 1'b0;
    pause(1);
    rd(8'hc8, 8'h00);
    rd(8'hca, 8'h00);
    rd(8'hcb, 8'h00);
    rd(8'hd8, 8'h00);
    wr(8'hc8, 8'h3b);
    wr(8'hc9, 8'hff);
    rd(8'hc9, 8'h00);
    rd(8'hc8, 8'h3b);
    wr(8'hca, 8'ha5);
    wr(8'hcb, 8'h5a);
    rd(8'hca, 8'ha5);
    rd(8'hcb, 8'h5a);
    wr(8'hc8, 8'h00);
    wr(8'hcc, 8'h10);
    pause(10);
    rd(8'hcc, 8'h10);
    wr(8'hc8, 8'h04);
    pause(18);
    wr(8'hc8, 8'h00);
    rdv(8'hcc, v);
    check("count step", v, 8'h1a);
    pause(6);
    rd(8'hcc, 8'h1a);
    wr(8'hcc, 8'h00);
    wr(8'hc8, 8'h06);
    repeat (3) begin
      cntPin <= 1'b0;
      pause(4);
      cntPin <= 1'b1;
      pause(4);
    end
    wr(8'hc8, 8'h00);
    rd(8'hcc, 8'h03);
    wr(8'hca, 8'h34);
    wr(8'hcb, 8'h12);
    wr(8'hda, 8'h01);
    wr(8'hcc, 8'hff);
    wr(8'hcd, 8'hff);
    wr(8'hc8, 8'h04);
    for (int i = 0; i < 20 && irq !== 1'b1; i++) pause(1);
    check("irq", {7'h00, irq}, 8'h01);
    wr(8'hc8, 8'h80);
    rd(8'hc8, 8'h80);
    rd(8'hcd, 8'h12);
    rd(8'hd8, 8'h01);
    wr(8'hda, 8'h00);
    check("irq masked", {7'h00, irq}, 8'h00);
    wr(8'hda, 8'h03);
    check("irq enabled", {7'h00, irq}, 8'h01);
    wr(8'hd9, 8'h01);
    check("irq cleared", {7'h00, irq}, 8'h00);
    wr(8'hc8, 8'h00);
    rd(8'hc8, 8'h00);
    wr(8'hcc, 8'h78);
    wr(8'hcd, 8'h56);
    wr(8'hc8, 8'h09);
    fall();
    rd(8'hca, 8'h78);
    rd(8'hcb, 8'h56);
    rd(8'hc8, 8'h49);
    rd(8'hd8, 8'h02);
    check("irq edge", {7'h00, irq}, 8'h01);
    wr(8'hd9, 8'h02);
    wr(8'hc8, 8'h01);
    wr(8'hcc, 8'h11);
    fall();
    rd(8'hc8, 8'h01);
    wr(8'hc8, 8'h29);
    fall();
    rd(8'hc8, 8'h29);
    rd(8'hca, 8'h78);
    wr(8'hcc, 8'h00);
    wr(8'hcd, 8'h00);
    wr(8'hc8, 8'h08);
    fall();
    rd(8'hcd, 8'h56);
    rd(8'hc8, 8'h48);
    uartMode <= 2'h1;
    wr(8'hc8, 8'h00);
    pulse();
    check("rx ticks", 8'(rxSeen), 8'h01);
    check("tx ticks", 8'(txSeen), 8'h01);
    uartMode <= 2'h0;
    pulse();
    uartMode <= 2'h3;
    wr(8'hc8, 8'h30);
    pulse();
    check("rx gated", 8'(rxSeen), 8'h01);
    check("tx gated", 8'(txSeen), 8'h01);
    wr(8'hca, 8'hff);
    wr(8'hcb, 8'hff);
    wr(8'hcc, 8'hff);
    wr(8'hcd, 8'hff);
    wr(8'hd9, 8'h03);
    wr(8'hc8, 8'h25);
    pause(20);
    rd(8'hc8, 8'h25);
    wr(8'hc8, 8'h00);
    rd(8'hcd, 8'hff);
    rd(8'hcc, 8'hff);
    rd(8'hd8, 8'h00);
    check("rx own", 8'(rxSeen > 8), 8'h01);
    check("tx other", 8'(txSeen), 8'h01);
    summarize();
  end
endmodule // testbench
`default_nettype wire
